/* pswd_pkg.sv */
// Package of constants and types for the pin-selectable watchdog
package pswd_pkg;
    // Clock rate in Hz
    localparam int unsigned CLK_HZ = 25000000;
    // Times in microseconds
    localparam longint unsigned T_30US = 30;
    localparam longint unsigned T_200US = 200;
    localparam longint unsigned T_SETTLE_US = 300;
    localparam longint unsigned T_1MS = 1000;
    localparam longint unsigned T_3MS = 3000;
    localparam longint unsigned T_10MS = 10000;
    localparam longint unsigned T_30MS = 30000;
    localparam longint unsigned T_100MS = 100000;
    localparam longint unsigned T_300MS = 300000;
    localparam longint unsigned T_1S = 1000000;
    localparam longint unsigned T_3S = 3000000;
    localparam longint unsigned T_10S = 10000000;
    localparam longint unsigned T_60S = 60000000;
    // Least pulse width in nanoseconds
    localparam longint unsigned T_MIN_PULSE_NS = 100;
    // Counter width for the longest period
    localparam int CNT_W = 32;
    // Disable code
    localparam logic [2:0] SEL_DISABLE = 3'h3;
    // Variant codes
    localparam logic [1:0] VAR_EQUAL = 2'h0;
    localparam logic [1:0] VAR_FIXED = 2'h1;
    localparam logic [1:0] VAR_EXTENDED = 2'h2;
    // Sentinel startup length meaning wait for first edge
    localparam logic [CNT_W-1:0] FIRST_EDGE = 32'hffffffff;
    // Least time to cycles, rounded up
    function automatic logic [CNT_W-1:0] us_to_cyc(input longint unsigned t_us);
        longint unsigned c;
        c = (t_us * longint'(CLK_HZ) + 64'd999999) / 64'd1000000;
        if (c < 1) c = 1;
        return c[CNT_W-1:0];
    endfunction
    // Least pulse width in cycles, rounded up
    localparam longint unsigned MIN_PULSE_CYC_L =
        (T_MIN_PULSE_NS * longint'(CLK_HZ) + 64'd999999999) / 64'd1000000000;
    localparam int MIN_PULSE_CYC = (MIN_PULSE_CYC_L < 1) ? 1 : int'(MIN_PULSE_CYC_L);
    // Main state machine
    typedef enum logic [4:0] {
        PSWD_SETTLE  = 5'b00001,
        PSWD_STARTUP = 5'b00010,
        PSWD_RUN     = 5'b00100,
        PSWD_FAULT   = 5'b01000,
        PSWD_OFF     = 5'b10000
    } pswd_state_e;
endpackage

/* pswd_if.sv */
// Interface carrying the synchronised strobe edge between the modules
`timescale 1ns/1ps
interface pswd_if;
    logic edge_seen; // One-cycle pulse per qualified strobe edge
    modport src (output edge_seen);
    modport dst (input edge_seen);
endinterface

/* pswd_strobe.sv */
// Strobe synchroniser, glitch filter and edge detector
`timescale 1ns/1ps
module pswd_strobe #(
    parameter int FILT_CYC = pswd_pkg::MIN_PULSE_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_strobe_in,
    pswd_if.src o_edge
);
    import pswd_pkg::*;
    logic sync1_reg, sync2_reg; // Two-stage synchroniser
    logic stable_reg, stable_next; // Accepted filtered level
    logic [7:0] run_reg, run_next; // Cycles the raw level differs from accepted
    logic edge_reg, edge_next; // Registered edge pulse

    // Filter: a level must hold FILT_CYC cycles to count
    always_comb begin
        stable_next = stable_reg;
        run_next = 8'h00;
        edge_next = 1'b0;
        if (sync2_reg != stable_reg) begin
            run_next = run_reg + 8'h01;
            if (run_next >= 8'(FILT_CYC)) begin
                stable_next = sync2_reg;
                edge_next = 1'b1; // Both directions count
                run_next = 8'h00;
            end
        end
    end

    // Registers; the first synchroniser stage feeds only the second
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            stable_reg <= 1'b0;
            run_reg <= 8'h00;
            edge_reg <= 1'b0;
        end else begin
            sync1_reg <= i_strobe_in;
            sync2_reg <= sync1_reg;
            stable_reg <= stable_next;
            run_reg <= run_next;
            edge_reg <= edge_next;
        end
    end

    assign o_edge.edge_seen = edge_reg;
endmodule // pswd_strobe

/* pswd_top.sv */
// Pin-selectable watchdog supervisor top level
// What this block does
// - Steady strobe for full timeout gives fault
// - Every strobe edge clears the timeout counter
// - Asserting the fault clears the counter
// - Regular strobes keep fault output high
// - Open-drain variant: fault at least 100ms
// - Push-pull variant: fault at least 1ms
// - Startup at power-up and on selection change
// - No counting nor fault during startup
// - After startup, time timeout, fault on expiry
// - Equal variant: delay equals timeout, table
// - Fixed variant: 60s delay, own timeout table
// - Extended variant: separate delay, timeout tables
// - First-edge mode waits for first strobe edge
// - Code 011 disables watchdog in all variants
// - Edges count only after 100ns stable level
// - Strobes ignored in fault and timed startup
// - 300us settle after change, fault finishes first
// - Fault end restarts a full timeout
`timescale 1ns/1ps
module pswd_top #(
    parameter logic [1:0] VARIANT = pswd_pkg::VAR_EQUAL, // Timing table
    parameter bit OPEN_DRAIN = 1'b1, // Output pulse flavour
    parameter logic [31:0] SETTLE_CYC = pswd_pkg::us_to_cyc(pswd_pkg::T_SETTLE_US),
    parameter logic [31:0] PULSE_OD_CYC = pswd_pkg::us_to_cyc(pswd_pkg::T_100MS),
    parameter logic [31:0] PULSE_PP_CYC = pswd_pkg::us_to_cyc(pswd_pkg::T_1MS),
    parameter int TIME_SHIFT = 0 // Right shift of table periods for fast simulation
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_strobe_in,
    input wire logic i_timing_sel_0,
    input wire logic i_timing_sel_1,
    input wire logic i_timing_sel_2,
    output logic o_fault_out_n,
    output logic o_fault_out_oe_n,
    output logic o_wd_active
);
    import pswd_pkg::*;
    // Every period is a count of i_sys_clk cycles taken at its minimum value.
    // TIME_SHIFT trades accuracy for run time in simulation only.
    // One counter is shared by all phases, since only one runs at a time.

    pswd_if strobe_bus (); // Edge pulses from the filter
    logic [2:0] sel_s1_reg, sel_s2_reg; // Selection synchroniser
    logic [2:0] sel_cur_reg, sel_cur_next; // Selection in force
    logic sel_chg_reg, sel_chg_next; // Pending change seen during fault
    pswd_state_e state_reg, state_next; // Main state
    logic [CNT_W-1:0] cnt_reg, cnt_next; // Shared period counter
    logic fault_n_reg, fault_n_next; // Output level
    logic oe_n_reg, oe_n_next; // Output enable, low drives
    logic act_reg, act_next; // Timeout timing active
    // Lookups below are pure decode of the code in force
    logic [CNT_W-1:0] dly_len, wd_len; // Decoded periods
    logic [CNT_W-1:0] pulse_len; // Output pulse width
    logic edge_ok; // Qualified strobe edge

    // Strobe filter and edge detector
    pswd_strobe u_strobe (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_strobe_in(i_strobe_in),
        .o_edge(strobe_bus.src)
    );

    // Edges arrive already filtered and registered
    assign edge_ok = strobe_bus.edge_seen;
    assign pulse_len = OPEN_DRAIN ? PULSE_OD_CYC : PULSE_PP_CYC;

    // Shorten a table period, never below one cycle
    // A zero length would fault at once, so one cycle is the floor
    function automatic logic [CNT_W-1:0] shorten(input logic [CNT_W-1:0] c);
        logic [CNT_W-1:0] r;
        r = c >> TIME_SHIFT;
        if (r == '0) r = 32'h00000001;
        return r;
    endfunction

    // Decode startup and timeout lengths for the variant
    always_comb begin
        dly_len = shorten(us_to_cyc(T_1MS));
        wd_len = shorten(us_to_cyc(T_1MS));
        unique case (VARIANT)
            // Fixed variant: one long startup, seven timeouts
            VAR_FIXED: begin
                dly_len = shorten(us_to_cyc(T_60S));
                unique case (sel_cur_reg)
                    3'h0: wd_len = shorten(us_to_cyc(T_1MS));
                    3'h1: wd_len = shorten(us_to_cyc(T_3MS));
                    3'h2: wd_len = shorten(us_to_cyc(T_10MS));
                    3'h4: wd_len = shorten(us_to_cyc(T_100MS));
                    3'h5: wd_len = shorten(us_to_cyc(T_300MS));
                    3'h6: wd_len = shorten(us_to_cyc(T_3S));
                    3'h7: wd_len = shorten(us_to_cyc(T_60S));
                    default: wd_len = shorten(us_to_cyc(T_1MS)); // Disable code, unused length
                endcase
            end
            // Extended variant: separate startup and timeout tables
            VAR_EXTENDED: begin
                unique case (sel_cur_reg)
                    3'h0: begin
                        dly_len = shorten(us_to_cyc(T_3MS));
                        wd_len = shorten(us_to_cyc(T_3MS));
                    end
                    3'h1: begin
                        dly_len = shorten(us_to_cyc(T_3S));
                        wd_len = shorten(us_to_cyc(T_3S));
                    end
                    3'h2: begin
                        dly_len = shorten(us_to_cyc(T_60S));
                        wd_len = shorten(us_to_cyc(T_1S));
                    end
                    3'h4: begin
                        dly_len = shorten(us_to_cyc(T_200US));
                        wd_len = shorten(us_to_cyc(T_30US));
                    end
                    3'h5: begin
                        dly_len = FIRST_EDGE;
                        wd_len = shorten(us_to_cyc(T_1S));
                    end
                    3'h6: begin
                        dly_len = FIRST_EDGE;
                        wd_len = shorten(us_to_cyc(T_10S));
                    end
                    3'h7: begin
                        dly_len = shorten(us_to_cyc(T_60S));
                        wd_len = shorten(us_to_cyc(T_10S));
                    end
                    default: begin
                        dly_len = shorten(us_to_cyc(T_1MS)); // Disable code
                        wd_len = shorten(us_to_cyc(T_1MS));
                    end
                endcase
            end
            // Equal variant: one table serves both periods
            // Also the fallback for an unused variant code
            default: begin
                unique case (sel_cur_reg)
                    3'h0: wd_len = shorten(us_to_cyc(T_1MS));
                    3'h1: wd_len = shorten(us_to_cyc(T_10MS));
                    3'h2: wd_len = shorten(us_to_cyc(T_30MS));
                    3'h4: wd_len = shorten(us_to_cyc(T_100MS));
                    3'h5: wd_len = shorten(us_to_cyc(T_1S));
                    3'h6: wd_len = shorten(us_to_cyc(T_10S));
                    3'h7: wd_len = shorten(us_to_cyc(T_60S));
                    default: wd_len = shorten(us_to_cyc(T_1MS)); // Disable code
                endcase
                dly_len = wd_len; // Startup equals timeout
            end
        endcase
    end

    // Next-state logic for the watchdog sequence
    // Each state clears the shared counter on its way out,
    // so the next phase always starts counting from zero.
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        sel_cur_next = sel_cur_reg;
        sel_chg_next = sel_chg_reg;
        fault_n_next = 1'b1;
        oe_n_next = 1'b1; // Released unless pulsing; push-pull drives high
        act_next = 1'b0;
        // Push-pull pin is driven at both levels
        if (!OPEN_DRAIN) begin
            oe_n_next = 1'b0;
        end
        // Selection change: fault finishes first, else settle now
        if (sel_s2_reg != sel_cur_reg) begin
            sel_cur_next = sel_s2_reg;
            if (state_reg == PSWD_FAULT) begin
                // Remember it; the running pulse keeps its full width
                sel_chg_next = 1'b1;
            end else begin
                // Any other phase drops its timing at once
                state_next = PSWD_SETTLE;
                cnt_next = '0;
            end
        end
        if (state_next == state_reg) begin
            unique case (state_reg)
                PSWD_SETTLE: begin
                    // Strobes ignored while settling
                    if (cnt_reg + 32'h00000001 >= SETTLE_CYC) begin
                        cnt_next = '0;
                        // Disable code parks the block instead of starting up
                        if (sel_cur_reg == SEL_DISABLE) begin
                            state_next = PSWD_OFF;
                        end else begin
                            state_next = PSWD_STARTUP;
                        end
                    end else begin
                        cnt_next = cnt_reg + 32'h00000001;
                    end
                end
                PSWD_STARTUP: begin
                    // No fault possible here; edges ignored unless first-edge mode
                    // Sentinel length: no timer, the first edge ends startup
                    if (dly_len == FIRST_EDGE) begin
                        if (edge_ok) begin
                            state_next = PSWD_RUN;
                            cnt_next = '0;
                        end
                    end else if (cnt_reg + 32'h00000001 >= dly_len) begin
                        state_next = PSWD_RUN;
                        cnt_next = '0;
                    end else begin
                        cnt_next = cnt_reg + 32'h00000001;
                    end
                end
                PSWD_RUN: begin
                    // Timeout timing; the status flag is set after the case
                    if (edge_ok) begin
                        // Host is alive: start the period again
                        cnt_next = '0;
                    end else if (cnt_reg + 32'h00000001 >= wd_len) begin
                        // Period used up with no edge: start the pulse
                        state_next = PSWD_FAULT;
                        cnt_next = '0;
                        fault_n_next = 1'b0;
                        oe_n_next = 1'b0;
                    end else begin
                        cnt_next = cnt_reg + 32'h00000001;
                    end
                end
                PSWD_FAULT: begin
                    // Edges ignored during the pulse
                    fault_n_next = 1'b0;
                    oe_n_next = 1'b0;
                    if (cnt_reg + 32'h00000001 >= pulse_len) begin
                        // Pulse complete: release the pin
                        fault_n_next = 1'b1;
                        oe_n_next = OPEN_DRAIN;
                        cnt_next = '0;
                        // A change in the last pulse cycle still counts: the flag is read before it clears
                        if (sel_chg_next) begin
                            state_next = PSWD_SETTLE;
                        end else begin
                            state_next = PSWD_RUN;
                        end
                        sel_chg_next = 1'b0;
                    end else begin
                        // Pulse still running
                        cnt_next = cnt_reg + 32'h00000001;
                    end
                end
                PSWD_OFF: begin
                    // Pin high, nothing counts; only a new code leaves
                    cnt_next = '0;
                end
                default: begin
                    // Illegal state code: recover through a fresh settle
                    state_next = PSWD_SETTLE;
                    cnt_next = '0;
                end
            endcase
        end
        // Status follows the state being entered, so it drops with the fault
        act_next = (state_next == PSWD_RUN);
    end

    // Pin synchronisers; only the second stage is read by logic
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            sel_s1_reg <= 3'h0;
            sel_s2_reg <= 3'h0;
        end else begin
            sel_s1_reg <= {i_timing_sel_2, i_timing_sel_1, i_timing_sel_0};
            sel_s2_reg <= sel_s1_reg;
        end
    end

    // Sequence registers; settle at reset stands for power-up
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            sel_cur_reg <= 3'h0;
            sel_chg_reg <= 1'b0;
            state_reg <= PSWD_SETTLE;
            cnt_reg <= '0;
            fault_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            act_reg <= 1'b0;
        end else begin
            sel_cur_reg <= sel_cur_next;
            sel_chg_reg <= sel_chg_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            fault_n_reg <= fault_n_next;
            oe_n_reg <= oe_n_next;
            act_reg <= act_next;
        end
    end

    // Every output comes straight from a flip-flop
    assign o_fault_out_n = fault_n_reg;
    assign o_fault_out_oe_n = oe_n_reg;
    assign o_wd_active = act_reg;
endmodule // pswd_top

/* pswd_chk_sva.sv */
// Port checker for the pin-selectable watchdog
`timescale 1ns/1ps
module pswd_chk #(
    parameter logic [1:0] VARIANT = 2'h0,
    parameter bit OPEN_DRAIN = 1'b1,
    parameter logic [31:0] SETTLE_CYC = 32'h14,
    parameter logic [31:0] PULSE_OD_CYC = 32'h32,
    parameter logic [31:0] PULSE_PP_CYC = 32'ha,
    parameter int TIME_SHIFT = 0
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_strobe_in,
    input wire logic i_timing_sel_0,
    input wire logic i_timing_sel_1,
    input wire logic i_timing_sel_2,
    input wire logic o_fault_out_n,
    input wire logic o_fault_out_oe_n,
    input wire logic o_wd_active
);
    import pswd_pkg::*;
    // Shortest table timeout; no fault can come sooner
    localparam logic [31:0] MIN_WD = ((VARIANT == VAR_EXTENDED) ? us_to_cyc(T_30US) : us_to_cyc(T_1MS)) >> TIME_SHIFT;
    localparam logic [31:0] PULSE = OPEN_DRAIN ? PULSE_OD_CYC : PULSE_PP_CYC;
    logic [2:0] sel; // Raw selection code
    logic sel_off; // Disable code on the pins
    logic [2:0] sel_prev_reg, sel_prev_next;
    logic strb_prev_reg, strb_prev_next;
    logic [31:0] low_reg, low_next; // Length of current fault pulse
    logic [31:0] strb_age_reg, strb_age_next; // Cycles since pin moved
    logic [31:0] sel_age_reg, sel_age_next; // Cycles since code moved
    assign sel = {i_timing_sel_2, i_timing_sel_1, i_timing_sel_0};
    assign sel_off = (sel == SEL_DISABLE);
    // Ages taken at the raw pins, so they do not lean on the design
    always_comb begin
        sel_prev_next = sel;
        strb_prev_next = i_strobe_in;
        low_next = o_fault_out_n ? 32'h0 : low_reg + 32'h1;
        strb_age_next = (i_strobe_in != strb_prev_reg) ? 32'h0 : strb_age_reg + 32'h1;
        sel_age_next = (sel != sel_prev_reg) ? 32'h0 : sel_age_reg + 32'h1;
    end
    // Registers; reset acts like a fresh power-up
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            sel_prev_reg <= sel;
            strb_prev_reg <= i_strobe_in;
            low_reg <= 32'h0;
            strb_age_reg <= 32'h0;
            sel_age_reg <= 32'h0;
        end else begin
            sel_prev_reg <= sel_prev_next;
            strb_prev_reg <= strb_prev_next;
            low_reg <= low_next;
            strb_age_reg <= strb_age_next;
            sel_age_reg <= sel_age_next;
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    chk_pulse_width: assert property ($rose(o_fault_out_n) |-> low_reg >= PULSE)
        else $error("fault pulse shorter than minimum");
    chk_fault_drive: assert property (!o_fault_out_n |-> !o_fault_out_oe_n)
        else $error("fault low but pin not driven");
    chk_pp_drive: assert property ((!OPEN_DRAIN && !$past(i_sys_rst)) |=> !o_fault_out_oe_n)
        else $error("push-pull pin released");
    chk_fault_cause: assert property ($fell(o_fault_out_n) |-> $past(o_wd_active) && strb_age_reg >= MIN_WD)
        else $error("fault without timeout");
    chk_restart_full: assert property ($rose(o_fault_out_n) |-> o_fault_out_n [*4])
        else $error("fault repeated too soon");
    chk_fault_idle: assert property (!o_fault_out_n |-> !o_wd_active)
        else $error("timing while fault asserted");
    chk_settle_idle: assert property ((sel_age_reg >= 32'h5 && sel_age_reg < SETTLE_CYC) |-> !o_wd_active)
        else $error("timing during settle");
    chk_off_quiet: assert property ((sel_off && sel_age_reg > SETTLE_CYC + PULSE + 32'h8) |->
        o_fault_out_n && !o_wd_active)
        else $error("disabled watchdog not idle");
    cover property ($fell(o_fault_out_n));
    cover property ($rose(o_wd_active));
    cover property (sel_off && sel_age_reg > SETTLE_CYC);
endmodule // pswd_chk

bind pswd_top pswd_chk #(.VARIANT(VARIANT), .OPEN_DRAIN(OPEN_DRAIN), .SETTLE_CYC(SETTLE_CYC),
    .PULSE_OD_CYC(PULSE_OD_CYC), .PULSE_PP_CYC(PULSE_PP_CYC), .TIME_SHIFT(TIME_SHIFT)) pswd_chk_inst (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_strobe_in(i_strobe_in),
    .i_timing_sel_0(i_timing_sel_0), .i_timing_sel_1(i_timing_sel_1), .i_timing_sel_2(i_timing_sel_2),
    .o_fault_out_n(o_fault_out_n), .o_fault_out_oe_n(o_fault_out_oe_n), .o_wd_active(o_wd_active));

/* pswd_host.sv */
// Host model that toggles the watchdog strobe pin
`timescale 1ns/1ps
module pswd_host (
    input wire logic i_clk,
    input wire logic i_run,
    input wire logic [15:0] i_half,
    output logic o_strobe
);
    int cnt = 0; // Cycles since last toggle
    initial o_strobe = 1'b0;
    // Toggle off the sampling edge; a level never lasts under 4 cycles
    always @(negedge i_clk) begin
        if (!i_run) begin
            cnt = 0; // Stuck host keeps its pin level
        end else if (cnt + 1 >= int'(i_half) && cnt >= 3) begin
            o_strobe <= ~o_strobe;
            cnt = 0;
        end else begin
            cnt = cnt + 1;
        end
    end
endmodule // pswd_host

/* pswd_top_bench.sv */
// Self-checking bench for the pin-selectable watchdog
`timescale 1ns/1ps
module pswd_top_bench;
    import pswd_pkg::*;
    localparam int SHIFT = 12; // Table periods divided by 4096
    localparam int SETTLE = 20; // Shortened settle in cycles
    localparam int PULSE = 10; // Shortened push-pull pulse
    localparam int LIM = 20000; // Bound of every wait
    int t_us[8] = '{1000, 10000, 30000, 0, 100000, 1000000, 10000000, 60000000}; // Equal table
    int codes[5] = '{0, 1, 2, 4, 5}; // Longer codes exceed the run budget
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] sel = 3'h0;
    logic run = 1'b0;
    logic [15:0] half = 16'h8;
    logic strobe, fault_n, oe_n, active;
    int fail_count = 0;
    int checks = 0;
    integer seed = 61774;
    int lows = 0; // Fault samples while monitoring
    logic mon = 1'b0;
    int n, wd;
    always #20 clk = ~clk;
    pswd_top #(.VARIANT(VAR_EQUAL), .OPEN_DRAIN(1'b0), .SETTLE_CYC(32'h14), .PULSE_OD_CYC(32'h32),
        .PULSE_PP_CYC(32'ha), .TIME_SHIFT(SHIFT)) pswd_top_inst (
        .i_sys_clk(clk), .i_sys_rst(rst), .i_strobe_in(strobe), .i_timing_sel_0(sel[0]),
        .i_timing_sel_1(sel[1]), .i_timing_sel_2(sel[2]), .o_fault_out_n(fault_n),
        .o_fault_out_oe_n(oe_n), .o_wd_active(active));
    pswd_host pswd_host_inst (.i_clk(clk), .i_run(run), .i_half(half), .o_strobe(strobe));
    // Count fault samples in a window
    always @(negedge clk) begin
        if (mon && fault_n !== 1'b1) lows++;
    end
    // Model: minimum period in cycles, 25 cycles per microsecond
    function automatic int exp_wd(input int code);
        return (t_us[code] * 25) >> SHIFT;
    endfunction
    task automatic end_sim();
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Counts: exact when lo equals hi; latency slack otherwise
    task automatic check_rng(input string what, input int lo, input int hi, input int got);
        checks++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask
    // Cycles until the fault pin shows a level, bounded
    task automatic wait_lvl(input logic lvl, output int cnt);
        cnt = 0;
        while (fault_n !== lvl && cnt < LIM) begin
            @(negedge clk);
            cnt++;
        end
        if (cnt >= LIM) begin
            fail_count++;
            $display("ERROR fault level %b expected seen timeout", lvl);
            end_sim();
        end
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        // Disabled code first: pin high, timers idle
        sel = 3'h3;
        mon = 1'b1;
        repeat (400) @(negedge clk);
        mon = 1'b0;
        check_rng("faults when off", 0, 0, lows);
        check_bit("active when off", 1'b0, active);
        // Each code: settle, startup, timeout, pulse, full restart
        foreach (codes[i]) begin
            wd = exp_wd(codes[i]);
            sel = codes[i][2:0];
            wait_lvl(1'b0, n);
            check_rng("first fault", SETTLE + 2 * wd, SETTLE + 2 * wd + 10, n);
            check_bit("drive enable", 1'b0, oe_n);
            check_bit("active in fault", 1'b0, active);
            wait_lvl(1'b1, n);
            check_rng("pulse width", PULSE, PULSE, n);
            wait_lvl(1'b0, n);
            check_rng("refault gap", wd, wd + 3, n);
            wait_lvl(1'b1, n);
            check_bit("active after pulse", 1'b1, active);
        end
        // Code change inside a pulse: pulse ends whole, then settle
        wait_lvl(1'b0, n);
        sel = 3'h4;
        wait_lvl(1'b1, n);
        check_rng("pulse on change", PULSE, PULSE, n);
        wait_lvl(1'b0, n);
        check_rng("fault after change", SETTLE + 2 * exp_wd(4), SETTLE + 2 * exp_wd(4) + 10, n);
        wait_lvl(1'b1, n);
        // Host strobes at random pace, from before startup ends
        sel = 3'h1;
        run = 1'b1;
        lows = 0;
        mon = 1'b1;
        repeat (20) begin
            half = 16'(4 + $unsigned($random(seed)) % 44);
            repeat (100) @(negedge clk);
        end
        run = 1'b0;
        mon = 1'b0;
        check_rng("faults while strobed", 0, 0, lows);
        wait_lvl(1'b0, n);
        check_rng("stop to fault", exp_wd(1) - 50, exp_wd(1) + 10, n);
        end_sim();
    end
endmodule // pswd_top_bench
